// File: hdl/clock_glitch_free_switch.sv
`timescale 1ns/1ps
module clock_glitch_free_switch #(
  parameter int unsigned N  = 2,
  parameter int unsigned SW = (N > 1) ? $clog2(N) : 1
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic [N-1:0]  src,
  input  wire logic [SW-1:0] sel,
  input  wire logic          gate,
  output logic               clk_out,
  output logic               busy
);
  import clock_mode_pkg::*;

  switch_state_e state_reg;
  switch_state_e state_next;
  logic [SW-1:0] cur_reg;
  logic          out_reg;
  logic          cur_level;
  logic          sel_level;
  logic          leave;
  logic          join_src;

  // Leave a source only while it is low, join a new one only while it is low
  assign cur_level = src[cur_reg];
  assign sel_level = src[sel];
  assign leave     = ((sel != cur_reg) || !gate) && !cur_level;
  assign join_src  = gate && (sel == cur_reg) && !sel_level;
  assign clk_out   = out_reg;
  assign busy      = (state_reg == SW_PARK) || (sel != cur_reg);

  // Park / follow sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SW_FOLLOW: if (leave) state_next = SW_PARK;
      SW_PARK:   if (join_src) state_next = SW_FOLLOW;
    endcase
  end

  // Output follows the source only in the follow state, so no pulse is cut short
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SW_PARK;
      cur_reg   <= '0;
      out_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == SW_PARK) cur_reg <= sel;
      out_reg   <= (state_reg == SW_FOLLOW) && !leave && cur_level;
    end
  end

endmodule // clock_glitch_free_switch

// File: hdl/clock_mode_pkg.sv
package clock_mode_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] SYS_CLOCK_CONTROL_OFS    = 8'h00;
  localparam logic [7:0] INT_RC_CONTROL_OFS       = 8'h04;
  localparam logic [7:0] SLOW_CRYSTAL_CONTROL_OFS = 8'h08;
  localparam logic [7:0] AUX_CONTROL_OFS          = 8'h0C;
  localparam logic [7:0] MODE_STATUS_OFS          = 8'h10;

  // Field positions, system clock control
  localparam int unsigned SCC_SEL_LSB  = 5;
  localparam int unsigned SCC_FHS_BIT  = 3;
  localparam int unsigned SCC_FSS_BIT  = 2;
  localparam int unsigned SCC_FKA_BIT  = 1;
  localparam int unsigned SCC_SKA_BIT  = 0;
  // Field positions, internal RC control
  localparam int unsigned RC_FREQ_LSB   = 2;
  localparam int unsigned RC_STABLE_BIT = 1;
  localparam int unsigned RC_EN_BIT     = 0;
  // Field positions, slow crystal control
  localparam int unsigned SX_SPEEDUP_BIT = 2;
  localparam int unsigned SX_STABLE_BIT  = 1;
  localparam int unsigned SX_EN_BIT      = 0;
  // Field positions, auxiliary control
  localparam int unsigned AUX_FX_EN_BIT  = 0;
  localparam int unsigned AUX_PIN_LSB    = 1;
  // Field positions, mode status
  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_FAST_BIT    = 3;
  localparam int unsigned ST_SLOW_BIT    = 4;
  localparam int unsigned ST_SYS_BIT     = 5;
  localparam int unsigned ST_BUSY_BIT    = 6;
  localparam int unsigned ST_LOCK_BIT    = 7;

  // Reset values
  localparam logic [2:0] SEL_RESET     = 3'h0;
  localparam logic [1:0] RC_FREQ_RESET = 2'h0;
  localparam logic       RC_EN_RESET   = 1'b1;
  localparam logic [1:0] PIN_RESET     = 2'h0;

  // Clock select and RC frequency codes
  localparam logic [2:0] SEL_SLOW  = 3'h7;
  localparam int unsigned DIV_TAPS = 7;
  localparam logic [1:0] RC_4MHZ   = 2'h0;
  localparam logic [1:0] RC_8MHZ   = 2'h1;
  localparam logic [1:0] RC_12MHZ  = 2'h2;

  // Slow crystal start-up times and their cycle counts at the core clock
  localparam int unsigned CORE_CLK_MHZ         = 40;
  localparam int unsigned SX_START_SPEEDUP_US  = 100;
  localparam int unsigned SX_START_LOWPOWER_US = 1000;
  localparam int unsigned SX_START_SPEEDUP_CYC  = SX_START_SPEEDUP_US * CORE_CLK_MHZ;
  localparam int unsigned SX_START_LOWPOWER_CYC = SX_START_LOWPOWER_US * CORE_CLK_MHZ;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_FAST              = 3'b000,
    MODE_SLOW              = 3'b001,
    MODE_SLEEP             = 3'b010,
    MODE_IDLE_SLOW_ONLY    = 3'b011,
    MODE_IDLE_BOTH_CLOCKS  = 3'b100,
    MODE_IDLE_FAST_ONLY    = 3'b101
  } op_mode_e;

  // Clock switch states
  typedef enum logic {
    SW_PARK   = 1'b0,
    SW_FOLLOW = 1'b1
  } switch_state_e;

endpackage

// File: hdl/clock_ratio_divider.sv
`timescale 1ns/1ps
module clock_ratio_divider #(
  parameter int unsigned TAPS = 7
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            fast_in,
  output logic [TAPS-1:0]      taps
);
  import clock_mode_pkg::*;

  logic [TAPS-2:0] cnt_reg;
  logic            prev_reg;

  // Count rising edges of the fast clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= '0;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= fast_in;
      if (fast_in && !prev_reg) cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Tap 0 is the fast clock, tap k is the fast clock over 2**k
  assign taps[0] = fast_in;
  genvar k;
  generate
    for (k = 1; k < TAPS; k++) begin : g_tap
      assign taps[k] = cnt_reg[k-1];
    end
  endgenerate

endmodule // clock_ratio_divider

// File: hdl/system_clock_mode_control.sv
// Function
// - Internal fast RC runs at 4, 8 or 12 MHz chosen by a two-bit field.
// - Field codes 00 is 4, 01 is 8, 10 is 12, 11 is 4 MHz.
// - Fast clock comes from the external fast crystal or the internal fast RC.
// - Fast-source bit 0 picks internal RC, 1 picks external crystal.
// - Slow clock comes from the external slow crystal or the internal slow RC.
// - Slow-source bit 0 picks internal slow RC, 1 picks external slow crystal.
// - In full-speed mode the system clock is fast clock divided by 1 to 64.
// - Select codes 000..110 give divide 1..64, code 111 gives the slow clock.
// - Six modes: fast and slow run the CPU, sleep and three idles halt it.
// - On halt the two keep-alive bits pick idle or sleep mode.
// - Idle modes run the system clock only when its source is kept alive.
// - After moving to the slow clock, fast oscillators follow their own enable bits.
// - In sleep the internal slow RC runs only while the watchdog is enabled.
// - Slow crystal speed-up bit 0 is low power, 1 is speed-up.
// - Speed-up writes are ignored while the slow crystal drives the system clock.
// - Both crystal modes work normally; low power only starts up slower.
// - After enabling, the slow crystal waits a start-up delay before use.
// - Unused slow crystal pins are released to I/O per pin-sharing bits.
`timescale 1ns/1ps
module system_clock_mode_control #(
  parameter int unsigned SX_START_SPEEDUP_CYCLES  = clock_mode_pkg::SX_START_SPEEDUP_CYC,
  parameter int unsigned SX_START_LOWPOWER_CYCLES = clock_mode_pkg::SX_START_LOWPOWER_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   internal_fast_rc,
  input  wire logic                   external_fast_crystal,
  input  wire logic                   internal_slow_rc,
  input  wire logic                   external_slow_crystal,
  input  wire logic                   int_rc_stable_raw,
  input  wire logic                   cpu_halt,
  input  wire logic                   watchdog_function,
  output logic                        system_clock,
  output logic                        fast_clock,
  output logic                        slow_clock,
  output logic                        internal_fast_rc_enable,
  output logic                        external_fast_crystal_enable,
  output logic                        internal_slow_rc_enable,
  output logic                        external_slow_crystal_enable,
  output logic                        slow_crystal_speedup,
  output logic [1:0]                  int_rc_freq_code,
  output logic                        slow_crystal_pins_osc,
  output logic [1:0]                  slow_crystal_pin_func,
  output clock_mode_pkg::op_mode_e    op_mode,
  output logic                        cpu_clock_run
);
  import clock_mode_pkg::*;

  localparam logic [15:0] SX_FAST_LIMIT = 16'(SX_START_SPEEDUP_CYCLES);
  localparam logic [15:0] SX_LP_LIMIT   = 16'(SX_START_LOWPOWER_CYCLES);

  // Software-visible control fields
  logic [2:0]  sys_clock_select_reg;
  logic        fast_source_select_reg;
  logic        slow_source_select_reg;
  logic        fast_keep_alive_reg;
  logic        slow_keep_alive_reg;
  logic [1:0]  int_rc_freq_select_reg;
  logic        int_rc_enable_reg;
  logic        slow_crystal_speedup_reg;
  logic        slow_crystal_enable_reg;
  logic        fast_crystal_enable_reg;
  logic [1:0]  pin_share_reg;
  // Synchronisers for the oscillator levels and the RC stable flag
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  // Start-up timer and registered outputs
  logic [15:0] sx_timer_reg;
  logic        sx_ready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        rc_on_reg;
  logic        fx_on_reg;
  logic        internal_slow_rc_on_reg;
  logic        lxt_on_reg;
  op_mode_e    mode_reg;
  logic        cpu_run_reg;

  logic        halted;
  op_mode_e    mode_now;
  logic        sel_is_slow;
  logic        fast_needed;
  logic        slow_needed;
  logic        sys_gate;
  logic        rc_on;
  logic        fx_on;
  logic        lxt_on;
  logic        internal_slow_rc_on;
  logic        fast_gate;
  logic        sx_lock;
  logic [15:0] sx_limit;
  logic        fast_level;
  logic        slow_level;
  logic        sys_level;
  logic        fast_busy;
  logic        slow_busy;
  logic        sys_busy;
  logic [DIV_TAPS-1:0] fast_taps;
  logic [7:0]  sys_sources;
  logic        bus_setup;
  logic        bus_write;
  logic        hit_scc;
  logic        hit_rc;
  logic        hit_sx;
  logic        hit_aux;
  logic        hit_st;
  logic        hit_any;
  logic [31:0] rd_scc;
  logic [31:0] rd_rc;
  logic [31:0] rd_sx;
  logic [31:0] rd_aux;
  logic [31:0] rd_st;
  logic [31:0] rd_mux;

  // Two-flop synchronisers for pin-level inputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {int_rc_stable_raw, external_slow_crystal, internal_slow_rc,
                    external_fast_crystal, internal_fast_rc};
      sync2_reg <= sync1_reg;
    end
  end

  // Operating mode from halt and keep-alive bits
  assign halted      = cpu_halt;
  assign sel_is_slow = (sys_clock_select_reg == SEL_SLOW);
  always_comb begin
    mode_now = MODE_FAST;
    if (!halted) begin
      mode_now = sel_is_slow ? MODE_SLOW : MODE_FAST;
    end else begin
      unique case ({fast_keep_alive_reg, slow_keep_alive_reg})
        2'b01: mode_now = MODE_IDLE_SLOW_ONLY;
        2'b11: mode_now = MODE_IDLE_BOTH_CLOCKS;
        2'b10: mode_now = MODE_IDLE_FAST_ONLY;
        2'b00: mode_now = MODE_SLEEP;
      endcase
    end
  end

  // Which clocks run in the current mode
  assign fast_needed = (mode_now == MODE_FAST) || (mode_now == MODE_IDLE_BOTH_CLOCKS) ||
                       (mode_now == MODE_IDLE_FAST_ONLY);
  assign slow_needed = (mode_now == MODE_FAST) || (mode_now == MODE_SLOW) ||
                       (mode_now == MODE_IDLE_SLOW_ONLY) || (mode_now == MODE_IDLE_BOTH_CLOCKS);
  assign sys_gate    = !halted || (mode_now == MODE_IDLE_BOTH_CLOCKS) ||
                       ((mode_now == MODE_IDLE_SLOW_ONLY) && sel_is_slow) ||
                       ((mode_now == MODE_IDLE_FAST_ONLY) && !sel_is_slow);

  // Oscillator enables; in slow mode the fast ones keep their own enable bits
  assign rc_on     = (!fast_source_select_reg && fast_needed) ||
                     (int_rc_enable_reg && (!halted || fast_keep_alive_reg));
  assign fx_on     = (fast_source_select_reg && fast_needed) ||
                     (fast_crystal_enable_reg && (!halted || fast_keep_alive_reg));
  assign lxt_on    = (slow_crystal_enable_reg || slow_source_select_reg) && slow_needed;
  assign internal_slow_rc_on   = (mode_now != MODE_SLEEP) || watchdog_function;
  assign fast_gate = fast_source_select_reg ? fx_on : rc_on;

  // Speed-up lock while the slow crystal is the system clock source
  assign sx_lock   = sel_is_slow && slow_source_select_reg;
  assign sx_limit  = slow_crystal_speedup_reg ? SX_FAST_LIMIT : SX_LP_LIMIT;

  // Fast source switch: 0 internal RC, 1 external crystal
  clock_glitch_free_switch #(.N(2)) u_fast_switch (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .src      (sync2_reg[1:0]),
    .sel      (fast_source_select_reg),
    .gate     (fast_gate),
    .clk_out  (fast_level),
    .busy     (fast_busy)
  );

  // Slow source switch: 0 internal RC, 1 external crystal only once started
  clock_glitch_free_switch #(.N(2)) u_slow_switch (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .src      ({sync2_reg[3] & sx_ready_reg, sync2_reg[2]}),
    .sel      (slow_source_select_reg),
    .gate     (slow_needed),
    .clk_out  (slow_level),
    .busy     (slow_busy)
  );

  // Fast clock divided by 1 to 64
  clock_ratio_divider #(.TAPS(DIV_TAPS)) u_divider (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fast_in  (fast_level),
    .taps     (fast_taps)
  );

  // System clock multiplexer over the divided taps and the slow clock
  assign sys_sources = {slow_level, fast_taps};
  clock_glitch_free_switch #(.N(8)) u_sys_switch (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .src      (sys_sources),
    .sel      (sys_clock_select_reg),
    .gate     (sys_gate),
    .clk_out  (sys_level),
    .busy     (sys_busy)
  );

  // APB decode; zero wait states
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite && hit_any;
  assign hit_scc   = (paddr == SYS_CLOCK_CONTROL_OFS);
  assign hit_rc    = (paddr == INT_RC_CONTROL_OFS);
  assign hit_sx    = (paddr == SLOW_CRYSTAL_CONTROL_OFS);
  assign hit_aux   = (paddr == AUX_CONTROL_OFS);
  assign hit_st    = (paddr == MODE_STATUS_OFS);
  assign hit_any   = hit_scc || hit_rc || hit_sx || hit_aux || hit_st;

  // Read images; unused bits read as zero
  assign rd_scc = 32'(sys_clock_select_reg) << SCC_SEL_LSB |
                  32'(fast_source_select_reg) << SCC_FHS_BIT |
                  32'(slow_source_select_reg) << SCC_FSS_BIT |
                  32'(fast_keep_alive_reg) << SCC_FKA_BIT |
                  32'(slow_keep_alive_reg) << SCC_SKA_BIT;
  assign rd_rc  = 32'(int_rc_freq_select_reg) << RC_FREQ_LSB |
                  32'(sync2_reg[4] & int_rc_enable_reg) << RC_STABLE_BIT |
                  32'(int_rc_enable_reg) << RC_EN_BIT;
  assign rd_sx  = 32'(slow_crystal_speedup_reg) << SX_SPEEDUP_BIT |
                  32'(sx_ready_reg) << SX_STABLE_BIT |
                  32'(slow_crystal_enable_reg) << SX_EN_BIT;
  assign rd_aux = 32'(fast_crystal_enable_reg) << AUX_FX_EN_BIT |
                  32'(pin_share_reg) << AUX_PIN_LSB;
  assign rd_st  = 32'(mode_reg) << ST_MODE_LSB |
                  32'(fast_needed) << ST_FAST_BIT |
                  32'(slow_needed) << ST_SLOW_BIT |
                  32'(sys_gate) << ST_SYS_BIT |
                  32'(fast_busy | slow_busy | sys_busy) << ST_BUSY_BIT |
                  32'(sx_lock) << ST_LOCK_BIT;
  assign rd_mux = hit_scc ? rd_scc : hit_rc ? rd_rc : hit_sx ? rd_sx :
                  hit_aux ? rd_aux : hit_st ? rd_st : 32'h0000_0000;

  // Register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_clock_select_reg     <= SEL_RESET;
      fast_source_select_reg   <= 1'b0;
      slow_source_select_reg   <= 1'b0;
      fast_keep_alive_reg      <= 1'b0;
      slow_keep_alive_reg      <= 1'b0;
      int_rc_freq_select_reg   <= RC_FREQ_RESET;
      int_rc_enable_reg        <= RC_EN_RESET;
      slow_crystal_speedup_reg <= 1'b0;
      slow_crystal_enable_reg  <= 1'b0;
      fast_crystal_enable_reg  <= 1'b0;
      pin_share_reg            <= PIN_RESET;
    end else if (bus_write) begin
      if (hit_scc) begin
        sys_clock_select_reg   <= pwdata[SCC_SEL_LSB +: 3];
        fast_source_select_reg <= pwdata[SCC_FHS_BIT];
        slow_source_select_reg <= pwdata[SCC_FSS_BIT];
        fast_keep_alive_reg    <= pwdata[SCC_FKA_BIT];
        slow_keep_alive_reg    <= pwdata[SCC_SKA_BIT];
      end
      if (hit_rc) begin
        int_rc_freq_select_reg <= pwdata[RC_FREQ_LSB +: 2];
        int_rc_enable_reg      <= pwdata[RC_EN_BIT];
      end
      if (hit_sx) begin
        if (!sx_lock) slow_crystal_speedup_reg <= pwdata[SX_SPEEDUP_BIT];
        slow_crystal_enable_reg <= pwdata[SX_EN_BIT];
      end
      if (hit_aux) begin
        fast_crystal_enable_reg <= pwdata[AUX_FX_EN_BIT];
        pin_share_reg           <= pwdata[AUX_PIN_LSB +: 2];
      end
    end
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (bus_setup) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !hit_any;
    end
  end

  // Slow crystal start-up delay, longer in low-power mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sx_timer_reg <= 16'h0000;
      sx_ready_reg <= 1'b0;
    end else if (!lxt_on) begin
      sx_timer_reg <= 16'h0000;
      sx_ready_reg <= 1'b0;
    end else if (sx_timer_reg < sx_limit) begin
      sx_timer_reg <= sx_timer_reg + 16'h0001;
    end else begin
      sx_ready_reg <= 1'b1;
    end
  end

  // Registered enables and mode outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_on_reg   <= RC_EN_RESET;
      fx_on_reg   <= 1'b0;
      internal_slow_rc_on_reg <= 1'b1;
      lxt_on_reg  <= 1'b0;
      mode_reg    <= MODE_FAST;
      cpu_run_reg <= 1'b0;
    end else begin
      rc_on_reg   <= rc_on;
      fx_on_reg   <= fx_on;
      internal_slow_rc_on_reg <= internal_slow_rc_on;
      lxt_on_reg  <= lxt_on;
      mode_reg    <= mode_now;
      cpu_run_reg <= !halted;
    end
  end

  // Outputs
  assign prdata                       = prdata_reg;
  assign pready                       = 1'b1;
  assign pslverr                      = pslverr_reg;
  assign system_clock                 = sys_level;
  assign fast_clock                   = fast_level;
  assign slow_clock                   = slow_level;
  assign internal_fast_rc_enable      = rc_on_reg;
  assign external_fast_crystal_enable = fx_on_reg;
  assign internal_slow_rc_enable      = internal_slow_rc_on_reg;
  assign external_slow_crystal_enable = lxt_on_reg;
  assign slow_crystal_speedup         = slow_crystal_speedup_reg;
  assign int_rc_freq_code             = (int_rc_freq_select_reg == RC_12MHZ) ? RC_12MHZ :
                                        (int_rc_freq_select_reg == RC_8MHZ) ? RC_8MHZ :
                                        RC_4MHZ;
  assign slow_crystal_pins_osc        = lxt_on_reg;
  assign slow_crystal_pin_func        = lxt_on_reg ? PIN_RESET : pin_share_reg;
  assign op_mode                      = mode_reg;
  assign cpu_clock_run                = cpu_run_reg;

endmodule // system_clock_mode_control

// File: tb/system_clock_mode_control_chk.sv
`timescale 1ns/1ps
module system_clock_mode_control_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cpu_halt,
  input wire logic watchdog_function,
  input wire logic system_clock,
  input wire logic internal_fast_rc_enable,
  input wire logic external_fast_crystal_enable,
  input wire logic internal_slow_rc_enable,
  input wire logic external_slow_crystal_enable,
  input wire logic slow_crystal_pins_osc,
  input wire logic [1:0] slow_crystal_pin_func,
  input wire clock_mode_pkg::op_mode_e op_mode,
  input wire logic cpu_clock_run
);
  import clock_mode_pkg::*;
  logic [5:0] slp_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Cycles spent in sleep, saturating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) slp_cnt <= 6'h00;
    else if (op_mode != MODE_SLEEP) slp_cnt <= 6'h00;
    else if (slp_cnt != 6'h3F) slp_cnt <= slp_cnt + 6'h01;
  end
  // Halt held over two edges
  sequence s_halt_held;
    cpu_halt [*2];
  endsequence
  // Mode, enable and pin relations
  a_run_flag: assert property (reset_n |=> cpu_clock_run == !$past(cpu_halt))
    else $error("cpu clock flag wrong");
  a_run_mode: assert property (reset_n && !cpu_halt |=> op_mode inside {MODE_FAST, MODE_SLOW})
    else $error("running mode wrong");
  a_halt_mode: assert property (s_halt_held |=> !(op_mode inside {MODE_FAST, MODE_SLOW}))
    else $error("halted mode wrong");
  a_internal_slow_rc_sleep: assert property
    (internal_slow_rc_enable == !(op_mode == MODE_SLEEP && !$past(watchdog_function))) else $error("slow rc wrong");
  a_fast_stop: assert property (op_mode inside {MODE_SLEEP, MODE_IDLE_SLOW_ONLY}
    |-> !internal_fast_rc_enable && !external_fast_crystal_enable) else $error("fast osc kept");
  a_lxt_stop: assert property (op_mode inside {MODE_SLEEP, MODE_IDLE_FAST_ONLY}
    |-> !external_slow_crystal_enable) else $error("slow crystal kept");
  a_pins_free: assert property (slow_crystal_pins_osc |-> slow_crystal_pin_func == 2'h0)
    else $error("pin code while in use");
  a_sleep_gate: assert property (slp_cnt == 6'h3F |-> !system_clock)
    else $error("system clock runs in sleep");
endmodule // system_clock_mode_control_chk

bind system_clock_mode_control system_clock_mode_control_chk i_chk (.*);

// File: tb/system_clock_mode_control_test.sv
`timescale 1ns/1ps
module system_clock_mode_control_test;
  import clock_mode_pkg::*;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, int_rc_stable_raw, cpu_halt, watchdog_function;
  logic internal_fast_rc, external_fast_crystal, internal_slow_rc, external_slow_crystal, system_clock, fast_clock;
  logic slow_clock, internal_fast_rc_enable, external_fast_crystal_enable, internal_slow_rc_enable, cpu_clock_run;
  logic external_slow_crystal_enable, slow_crystal_speedup, slow_crystal_pins_osc;
  logic [1:0] int_rc_freq_code, slow_crystal_pin_func;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [65:0] exp_q[$], ent;
  logic [4:0] cyc = 5'h00;
  op_mode_e op_mode;
  op_mode_e hm[4] = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY, MODE_IDLE_BOTH_CLOCKS};
  int n_fail, n_checks;

  system_clock_mode_control #(.SX_START_SPEEDUP_CYCLES(8), .SX_START_LOWPOWER_CYCLES(20)) i_dut (.*);

  // Core clock at 40 MHz, oscillators at 10, 5, 2.5 and 1.25 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 5'h01;
  assign {external_slow_crystal, internal_slow_rc, external_fast_crystal, internal_fast_rc} = cyc[4:1];

  task automatic chk(input logic [32:0] s, input logic [32:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer, then an idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'($urandom), d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back({m, e & m});
    bus(a, 1'b0, 32'($urandom));
  endtask

  // Counts rising edges of the fast or system clock over 256 cycles
  task automatic rate(input logic f, input int e);
    int c;
    logic p, v;
    c = 0;
    p = 1'b1;
    repeat (40) @(posedge core_clk);
    repeat (256) begin
      @(negedge core_clk);
      v = f ? fast_clock : system_clock;
      if (v === 1'b1 && p !== 1'b1) c++;
      p = v;
    end
    @(posedge core_clk);
    chk(33'(c >= e - 1 && c <= e + 1), 33'h1, "rising edges");
  endtask

  // Compares each read with the oldest note
  always @(posedge core_clk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      chk({pslverr, prdata} & ent[65:33], ent[32:0], "read");
    end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, cpu_halt, watchdog_function} = '0;
    reset_n = 1'b0;
    int_rc_stable_raw = 1'b1;
    void'($urandom(53));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk); // Stable flag needs its synchroniser refilled
    rd(8'h04, 33'h3, 33'h1FFFFFFFF);
    rd(8'h14, 33'h100000000, 33'h1FFFFFFFF);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 8'(c * 4 + 1));
      chk(33'(int_rc_freq_code), 33'(c % 3), "rc code");
      rd(8'h04, 33'(c * 4 + 1), 33'hD);
    end
    wr(8'h04, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, {k[2] ? 3'h7 : 3'h0, 3'h0, k[1:0]});
      cpu_halt <= 1'b1;
      watchdog_function <= k[2];
      repeat (70) @(posedge core_clk);
      rd(8'h10, {27'h0, k[1:0] == 3 || k[1:0] == 1 && k[2] || k[1:0] == 2 && !k[2], 2'h0, hm[k[1:0]]}, 33'h27);
      chk(33'(op_mode), 33'(hm[k[1:0]]), "mode");
      cpu_halt <= 1'b0;
      @(posedge core_clk);
      rd(8'h10, {30'h0, k[2] ? MODE_SLOW : MODE_FAST}, 33'h7);
    end
    wr(8'h0C, 8'h05);
    wr(8'h08, 8'h05);
    chk(33'(slow_crystal_speedup), 33'h1, "speed-up");
    wr(8'h00, 8'hE4);
    wr(8'h08, 8'h01);
    rd(8'h08, 33'h5, 33'h5);
    rd(8'h10, 33'h80, 33'h80);
    repeat (20) @(posedge core_clk);
    rd(8'h08, 33'h7, 33'h7);
    chk({29'h0, external_slow_crystal_enable, slow_crystal_pins_osc, slow_crystal_pin_func}, 33'hC, "pins");
    chk({31'h0, internal_fast_rc_enable, external_fast_crystal_enable}, 33'h3, "fast enables");
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({31'h0, slow_crystal_pin_func}, 33'h2, "pin code");
    wr(8'h00, 8'hE4);
    rd(8'h08, 33'h0, 33'h2);
    repeat (25) @(posedge core_clk);
    rd(8'h08, 33'h2, 33'h2);
    for (int d = 0; d < 7; d++) begin
      wr(8'h00, 8'(d * 32));
      rate(1'b0, 64 >> d);
    end
    rate(1'b1, 64);
    wr(8'h00, 8'h08);
    rate(1'b1, 32);
    wr(8'h00, 8'hE0);
    rate(1'b0, 16);
    test_done;
  end

  // Cuts a hang short
  initial begin
    #500000;
    n_fail++;
    test_done;
  end
endmodule // system_clock_mode_control_test
